// ---- verif/epiu_pin_source.sv ----
// pin source model: external circuits driving the interrupt pins
`timescale 1ns/1ps
`default_nettype none
module epiu_pin_source (
  input wire logic mclk,
  output logic [epiu_pkg::EPIU_N_DED-1:0] dedicated_irq_pin,
  output logic [epiu_pkg::EPIU_N_PCH-1:0] change_watch_pin
);
  import epiu_pkg::*;
  initial begin
    dedicated_irq_pin = 8'hFF;
    change_watch_pin = 13'h0000;
  end
  // =====================================================================
  // levels launched after an edge and held until the next call
  task automatic drive_ded(input logic [EPIU_N_DED-1:0] v);
    @(posedge mclk);
    dedicated_irq_pin <= v;
  endtask
  task automatic drive_chg(input logic [EPIU_N_PCH-1:0] v);
    @(posedge mclk);
    change_watch_pin <= v;
  endtask
endmodule
`default_nettype wire

// ---- verif/epiu_top_properties.sv ----
// checker: port-level properties of the pin interrupt unit
`timescale 1ns/1ps
`default_nettype none
module epiu_top_properties (
  input wire logic mclk,
  input wire logic rst_b,
  input wire epiu_pkg::epiu_addr_t reg_addr,
  input wire epiu_pkg::epiu_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire epiu_pkg::epiu_byte_t reg_rdata,
  input wire logic [epiu_pkg::EPIU_N_DED-1:0] dedicated_irq_pin,
  input wire logic [epiu_pkg::EPIU_N_PCH-1:0] change_watch_pin,
  input wire logic global_irq_enable,
  input wire logic [epiu_pkg::EPIU_N_DED-1:0] ext_irq_req,
  input wire logic [epiu_pkg::EPIU_N_GRP-1:0] group_irq_req
);
  import epiu_pkg::*;
  epiu_byte_t mask_r;
  epiu_byte_t sense_r;
  epiu_byte_t grp_r;
  epiu_byte_t pcm_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // =====================================================================
  // shadow of the mask, low sense, group enable and low pin-change mask registers, updated on the same edge as the design
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mask_r <= '0;
      sense_r <= '0;
      grp_r <= '0;
      pcm_r <= '0;
    end else if (reg_wr) begin
      if (reg_addr == EPIU_OFS_EXT_MASK) mask_r <= reg_wdata;
      if (reg_addr == EPIU_OFS_SENSE_LO) sense_r <= reg_wdata;
      if (reg_addr == EPIU_OFS_GRP_EN) grp_r <= reg_wdata;
      if (reg_addr == EPIU_OFS_PCM_LO) pcm_r <= reg_wdata;
    end
  end
  // =====================================================================
  // properties
  a_req_needs_gie: assert property (
    !global_irq_enable |-> (ext_irq_req == '0) && (group_irq_req == '0))
    else $error("request without global enable");
  a_mask_gates_req: assert property (
    (ext_irq_req & ~mask_r) == '0) else $error("request on a masked input");
  a_grp_gates_req: assert property (
    (group_irq_req & ~grp_r[1:0]) == '0) else $error("request on a disabled group");
  a_level_req: assert property (
    sense_r[1:0] == 2'b00 && mask_r[0] && global_irq_enable && !dedicated_irq_pin[0]
    |-> ext_irq_req[0]) else $error("level request missing");
  a_rise_req: assert property (
    ($rose(dedicated_irq_pin[0]) && sense_r[1:0] == 2'b11 && mask_r[0] && !reg_wr)
    ##1 global_irq_enable |-> ext_irq_req[0]) else $error("rising edge lost");
  a_level_flag_zero: assert property (
    reg_rd && reg_addr == EPIU_OFS_EXT_FLAGS && sense_r[1:0] == 2'b00
    |=> !reg_rdata[0]) else $error("level flag reads set");
  a_group_change: assert property (
    ($changed(change_watch_pin[0]) && pcm_r[0] && grp_r[0] && !reg_wr)
    ##1 global_irq_enable |-> group_irq_req[0]) else $error("pin change lost");
  a_pcm_hi_unused: assert property (
    reg_rd && reg_addr == EPIU_OFS_PCM_HI |=> reg_rdata[7:5] == 3'h0)
    else $error("unused mask bits read set");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == '0) else $error("read data outside read slot");
endmodule
bind epiu_top epiu_top_properties epiu_top_properties_inst (.mclk(mclk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .dedicated_irq_pin(dedicated_irq_pin),
  .change_watch_pin(change_watch_pin), .global_irq_enable(global_irq_enable),
  .ext_irq_req(ext_irq_req), .group_irq_req(group_irq_req));
`default_nettype wire

// ---- verif/tb.sv ----
// testbench: register and pin scenarios for the pin interrupt unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  import epiu_pkg::*;
  logic mclk, rst_b, reg_wr, reg_rd, global_irq_enable, sleep_active, io_clk_en;
  epiu_addr_t reg_addr;
  epiu_byte_t reg_wdata;
  epiu_byte_t reg_rdata;
  logic [EPIU_N_DED-1:0] ded_pin, ext_ack, ext_req;
  logic [EPIU_N_PCH-1:0] chg_pin;
  logic [EPIU_N_GRP-1:0] grp_ack, grp_req;
  int error_cnt = 0;
  int samples_checked = 0;
  epiu_addr_t amap [8] = '{8'h3B, 8'h3C, 8'h3D, 8'h68, 8'h69, 8'h6A, 8'h6B, 8'h6C};
  epiu_byte_t ffexp [8] = '{8'h00, 8'h00, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'h1F};
  epiu_top epiu_top_inst (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dedicated_irq_pin(ded_pin), .change_watch_pin(chg_pin),
    .global_irq_enable(global_irq_enable), .sleep_active(sleep_active),
    .io_clk_en(io_clk_en), .ext_vector_ack(ext_ack), .group_vector_ack(grp_ack),
    .ext_irq_req(ext_req), .group_irq_req(grp_req));
  epiu_pin_source epiu_pin_source_inst (.mclk(mclk), .dedicated_irq_pin(ded_pin),
    .change_watch_pin(chg_pin));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // =====================================================================
  // bus and check tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input epiu_addr_t a, input epiu_byte_t d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input epiu_addr_t a, input epiu_byte_t exp, input string what);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp, what);
  endtask
  task automatic step;
    @(posedge mclk);
    #1;
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    finish_test;
  end
  // =====================================================================
  // tests
  initial begin
    {rst_b, reg_wr, reg_rd, sleep_active, reg_addr, reg_wdata, ext_ack, grp_ack} = '0;
    global_irq_enable = 1'b1;
    io_clk_en = 1'b1;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) rd(amap[i], 8'h00, "reset value");
    for (int i = 2; i < 8; i++) wr(amap[i], 8'hFF);
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h00, "unmapped");
    for (int i = 0; i < 8; i++) rd(amap[i], ffexp[i], "implemented bits");
    for (int i = 2; i < 8; i++) wr(amap[i], 8'h00);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      wr(EPIU_OFS_SENSE_LO, {4{m[1:0]}});
      wr(EPIU_OFS_SENSE_HI, {4{m[1:0]}});
      wr(EPIU_OFS_EXT_FLAGS, 8'hFF);
      epiu_pin_source_inst.drive_ded(8'h00);
      rd(EPIU_OFS_EXT_FLAGS, (m == 1 || m == 2) ? 8'hFF : 8'h00, "fall");
      wr(EPIU_OFS_EXT_FLAGS, 8'hFF);
      rd(EPIU_OFS_EXT_FLAGS, 8'h00, "flag write one");
      epiu_pin_source_inst.drive_ded(8'hFF);
      rd(EPIU_OFS_EXT_FLAGS, (m == 1 || m == 3) ? 8'hFF : 8'h00, "rise");
    end
    $display("test sense modes done");
    wr(EPIU_OFS_SENSE_LO, 8'h00);
    wr(EPIU_OFS_SENSE_HI, 8'h00);
    wr(EPIU_OFS_EXT_MASK, 8'hFF);
    epiu_pin_source_inst.drive_ded(8'h5A);
    step;
    chk(ext_req, 8'hA5, "level request");
    rd(EPIU_OFS_EXT_FLAGS, 8'h00, "level flags");
    @(posedge mclk);
    global_irq_enable <= 1'b0;
    #1 chk(ext_req, 8'h00, "global off");
    wr(EPIU_OFS_EXT_MASK, 8'h00);
    epiu_pin_source_inst.drive_ded(8'hFF);
    global_irq_enable <= 1'b1;
    wr(EPIU_OFS_SENSE_LO, 8'hFF);
    wr(EPIU_OFS_SENSE_HI, 8'hFF);
    wr(EPIU_OFS_EXT_FLAGS, 8'hFF);
    wr(EPIU_OFS_EXT_MASK, 8'h0F);
    epiu_pin_source_inst.drive_ded(8'h00);
    epiu_pin_source_inst.drive_ded(8'hFF);
    step;
    chk(ext_req, 8'h0F, "masked requests");
    @(posedge mclk);
    ext_ack <= 8'h01;
    @(posedge mclk);
    ext_ack <= 8'h00;
    rd(EPIU_OFS_EXT_FLAGS, 8'hFE, "vector clear");
    $display("test enables done");
    epiu_pin_source_inst.drive_ded(8'h00);
    wr(EPIU_OFS_EXT_FLAGS, 8'hFF);
    io_clk_en <= 1'b0;
    epiu_pin_source_inst.drive_ded(8'hFF);
    rd(EPIU_OFS_EXT_FLAGS, 8'h0F, "no io tick");
    @(posedge mclk);
    io_clk_en <= 1'b1;
    rd(EPIU_OFS_EXT_FLAGS, 8'hFF, "io tick");
    epiu_pin_source_inst.drive_ded(8'h00);
    fork
      epiu_pin_source_inst.drive_ded(8'hFF);
      wr(EPIU_OFS_EXT_FLAGS, 8'hFF);
    join
    rd(EPIU_OFS_EXT_FLAGS, 8'hFF, "set beats clear");
    $display("test io clock done");
    wr(EPIU_OFS_GRP_EN, 8'h03);
    wr(EPIU_OFS_PCM_LO, 8'h01);
    wr(EPIU_OFS_PCM_HI, 8'h10);
    epiu_pin_source_inst.drive_chg(13'h0802);
    rd(EPIU_OFS_PCH_FLAGS, 8'h00, "unmasked pins");
    epiu_pin_source_inst.drive_chg(13'h0803);
    step;
    chk({6'h00, grp_req}, 8'h01, "group low");
    epiu_pin_source_inst.drive_chg(13'h1803);
    step;
    chk({6'h00, grp_req}, 8'h03, "group high");
    wr(EPIU_OFS_GRP_EN, 8'h00);
    #1 chk({6'h00, grp_req}, 8'h00, "group disabled");
    wr(EPIU_OFS_PCH_FLAGS, 8'h01);
    rd(EPIU_OFS_PCH_FLAGS, 8'h02, "group write one");
    @(posedge mclk);
    grp_ack <= 2'b10;
    @(posedge mclk);
    grp_ack <= 2'b00;
    rd(EPIU_OFS_PCH_FLAGS, 8'h00, "group vector");
    $display("test pin change done");
    wr(EPIU_OFS_EXT_MASK, 8'h03);
    wr(EPIU_OFS_SENSE_LO, 8'h55);
    wr(EPIU_OFS_EXT_FLAGS, 8'hFF);
    @(posedge mclk);
    sleep_active <= 1'b1;
    rd(EPIU_OFS_EXT_FLAGS, 8'h0C, "sleep buffers");
    wr(EPIU_OFS_EXT_FLAGS, 8'hFF);
    @(posedge mclk);
    sleep_active <= 1'b0;
    rd(EPIU_OFS_EXT_FLAGS, 8'h0C, "sleep exit");
    $display("test sleep done");
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    rd(EPIU_OFS_EXT_MASK, 8'h00, "mask after reset");
    rd(EPIU_OFS_SENSE_LO, 8'h00, "sense after reset");
    chk(ext_req, 8'h00, "requests after reset");
    $display("test mid-run reset done");
    finish_test;
  end
endmodule
`default_nettype wire

// ---- verilog/epiu_change_group.sv ----
// module: masked change detector for one pin-change group
`timescale 1ns/1ps
`default_nettype none
module epiu_change_group #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [W-1:0] pins,
  input wire logic [W-1:0] mask,
  output logic change
);
  import epiu_pkg::*;

  logic [W-1:0] prev_r;

  // =====================================================================
  // previous level of every pin, masked or not, so unmasking never fakes a change
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prev_r <= '0;
    end else begin
      prev_r <= pins;
    end
  end

  // change seen in the same cycle the pin moves, with no extra sample stage
  assign change = |((pins ^ prev_r) & mask);

endmodule
`default_nettype wire

// ---- verilog/epiu_pkg.sv ----
// package: constants, register map and types of the external pin interrupt unit
package epiu_pkg;

  // =====================================================================
  // widths
  localparam int EPIU_DW = 8;
  localparam int EPIU_AW = 8;
  localparam int EPIU_N_DED = 8;
  localparam int EPIU_N_ASYNC = 4;
  localparam int EPIU_N_PCH = 13;
  localparam int EPIU_N_PCH_LO = 8;
  localparam int EPIU_N_PCH_HI = 5;
  localparam int EPIU_N_GRP = 2;
  localparam int EPIU_SENSE_W = 2;

  typedef logic [EPIU_AW-1:0] epiu_addr_t;
  typedef logic [EPIU_DW-1:0] epiu_byte_t;

  // =====================================================================
  // register offsets
  localparam epiu_addr_t EPIU_OFS_PCH_FLAGS = 8'h3B;
  localparam epiu_addr_t EPIU_OFS_EXT_FLAGS = 8'h3C;
  localparam epiu_addr_t EPIU_OFS_EXT_MASK = 8'h3D;
  localparam epiu_addr_t EPIU_OFS_GRP_EN = 8'h68;
  localparam epiu_addr_t EPIU_OFS_SENSE_LO = 8'h69;
  localparam epiu_addr_t EPIU_OFS_SENSE_HI = 8'h6A;
  localparam epiu_addr_t EPIU_OFS_PCM_LO = 8'h6B;
  localparam epiu_addr_t EPIU_OFS_PCM_HI = 8'h6C;

  // =====================================================================
  // reset values and implemented bits
  localparam epiu_byte_t EPIU_RST_BYTE = 8'h00;
  localparam epiu_byte_t EPIU_BITS_GRP = 8'h03;
  localparam epiu_byte_t EPIU_BITS_PCM_HI = 8'h1F;
  localparam epiu_byte_t EPIU_BITS_ALL = 8'hFF;
  localparam epiu_byte_t EPIU_READ_NONE = 8'h00;

  // group bit positions in the group enable and group flag registers
  localparam int EPIU_GRP_LO = 0;
  localparam int EPIU_GRP_HI = 1;

  // level seen by the logic when a pin's input buffer is switched off in sleep
  localparam logic EPIU_BUF_OFF_LEVEL = 1'b0;

  // =====================================================================
  // sense modes of a dedicated input
  typedef enum logic [1:0] {
    EPIU_SENSE_LOW = 2'b00,
    EPIU_SENSE_ANY = 2'b01,
    EPIU_SENSE_FALL = 2'b10,
    EPIU_SENSE_RISE = 2'b11
  } epiu_sense_t;

endpackage

// ---- verilog/epiu_sense_decode.sv ----
// module: trigger decode of one dedicated interrupt input
`timescale 1ns/1ps
`default_nettype none
module epiu_sense_decode (
  input wire epiu_pkg::epiu_sense_t mode,
  input wire logic cur,
  input wire logic prev,
  input wire logic sample_ok,
  output logic is_level,
  output logic low_level,
  output logic edge_hit
);
  import epiu_pkg::*;

  // =====================================================================
  // edge classes between previous and current level
  wire rise = cur & ~prev;
  wire fall = ~cur & prev;
  wire any_change = cur ^ prev;
  wire raw_hit;

  assign raw_hit = (mode == EPIU_SENSE_ANY) ? any_change :
                   (mode == EPIU_SENSE_FALL) ? fall :
                   (mode == EPIU_SENSE_RISE) ? rise : 1'b0;
  assign is_level = (mode == EPIU_SENSE_LOW);
  assign low_level = is_level & ~cur;
  assign edge_hit = raw_hit & sample_ok;

endmodule
`default_nettype wire

// ---- verilog/epiu_top.sv ----
// module: external and pin-change interrupt unit with register port
//
// Behaviour
// (RQ1) inputs 0-3: two-bit sense, edges unsampled
// (RQ2) inputs 4-7: two-bit sense between successive samples
// (RQ3) inputs 0-3 catch edges without sampling stage
// (RQ4) inputs 4-7 sampled first; one-clock pulses caught
// (RQ5) source holds low level until instruction ends
// (RQ6) level mode requests while pin low
// (RQ7) request needs pin enable and global enable
// (RQ8) pin activity triggers even as output
// (RQ9) software disables, resenses, clears flag, re-enables
// (RQ10) dedicated flag set by trigger, cleared by vector/W1C
// (RQ11) flag reads cleared in level mode
// (RQ12) sleep with 0-3 disabled gates their buffers
// (RQ13) group enable plus global enable raises group
// (RQ14) group flag set on change, vector/W1C clears
// (RQ15) low mask selects pins 0-7 for group 0
// (RQ16) high mask bits 4:0 select pins 8-12
// (RQ17) pin changes detected without sampling stage
// (RQ18) 4-7 edges need io clock; levels do not
// (RQ19) request lines are flag (pin low in level mode) AND enable AND global
`timescale 1ns/1ps
`default_nettype none
module epiu_top (
  input wire logic mclk,
  input wire logic rst_b,
  input wire epiu_pkg::epiu_addr_t reg_addr,
  input wire epiu_pkg::epiu_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output epiu_pkg::epiu_byte_t reg_rdata,
  input wire logic [epiu_pkg::EPIU_N_DED-1:0] dedicated_irq_pin,
  input wire logic [epiu_pkg::EPIU_N_PCH-1:0] change_watch_pin,
  input wire logic global_irq_enable,
  input wire logic sleep_active,
  input wire logic io_clk_en,
  input wire logic [epiu_pkg::EPIU_N_DED-1:0] ext_vector_ack,
  input wire logic [epiu_pkg::EPIU_N_GRP-1:0] group_vector_ack,
  output logic [epiu_pkg::EPIU_N_DED-1:0] ext_irq_req,
  output logic [epiu_pkg::EPIU_N_GRP-1:0] group_irq_req
);
  import epiu_pkg::*;

  // =====================================================================
  // functions
  // sticky flag update: a set in the same cycle as a clear wins
  function automatic epiu_byte_t flag_next(input epiu_byte_t cur, input epiu_byte_t set,
                                           input epiu_byte_t clr);
    flag_next = (cur & ~clr) | set;
  endfunction

  // register write with only the implemented bits kept
  function automatic epiu_byte_t masked_write(input epiu_byte_t data, input epiu_byte_t bits);
    masked_write = data & bits;
  endfunction

  // inputs whose buffer is off read the fixed level, each bit on its own
  function automatic logic [EPIU_N_ASYNC-1:0] buf_gate(input logic [EPIU_N_ASYNC-1:0] pin,
                                                       input logic [EPIU_N_ASYNC-1:0] off);
    buf_gate = (pin & ~off) | ({EPIU_N_ASYNC{EPIU_BUF_OFF_LEVEL}} & off);
  endfunction

  // request gate shared by the dedicated inputs and the groups
  function automatic epiu_byte_t req_gate(input epiu_byte_t active, input epiu_byte_t en,
                                          input logic gie);
    req_gate = active & en & {EPIU_DW{gie}};
  endfunction

  // sense code of one dedicated input out of the two packed sense registers
  function automatic epiu_sense_t sense_field(input logic [EPIU_SENSE_W*EPIU_N_DED-1:0] packed_sense,
                                              input int idx);
    sense_field = epiu_sense_t'(packed_sense[EPIU_SENSE_W*idx +: EPIU_SENSE_W]);
  endfunction

  // =====================================================================
  // registers
  epiu_byte_t sense_lo_r;
  epiu_byte_t sense_hi_r;
  epiu_byte_t ext_mask_r;
  epiu_byte_t ext_flag_r;
  epiu_byte_t ext_flag_nxt;
  epiu_byte_t grp_en_r;
  epiu_byte_t grp_flag_r;
  epiu_byte_t grp_flag_nxt;
  epiu_byte_t pcm_lo_r;
  epiu_byte_t pcm_hi_r;
  epiu_byte_t rdata_r;
  epiu_byte_t rdata_nxt;
  logic [EPIU_N_ASYNC-1:0] async_prev_r;
  logic [EPIU_N_DED-EPIU_N_ASYNC-1:0] sample_r;

  // =====================================================================
  // address decode
  wire hit_pch_flags = (reg_addr == EPIU_OFS_PCH_FLAGS);
  wire hit_ext_flags = (reg_addr == EPIU_OFS_EXT_FLAGS);
  wire hit_ext_mask = (reg_addr == EPIU_OFS_EXT_MASK);
  wire hit_grp_en = (reg_addr == EPIU_OFS_GRP_EN);
  wire hit_sense_lo = (reg_addr == EPIU_OFS_SENSE_LO);
  wire hit_sense_hi = (reg_addr == EPIU_OFS_SENSE_HI);
  wire hit_pcm_lo = (reg_addr == EPIU_OFS_PCM_LO);
  wire hit_pcm_hi = (reg_addr == EPIU_OFS_PCM_HI);

  wire wr_pch_flags = reg_wr & hit_pch_flags;
  wire wr_ext_flags = reg_wr & hit_ext_flags;
  wire wr_ext_mask = reg_wr & hit_ext_mask;
  wire wr_grp_en = reg_wr & hit_grp_en;
  wire wr_sense_lo = reg_wr & hit_sense_lo;
  wire wr_sense_hi = reg_wr & hit_sense_hi;
  wire wr_pcm_lo = reg_wr & hit_pcm_lo;
  wire wr_pcm_hi = reg_wr & hit_pcm_hi;

  // =====================================================================
  // dedicated inputs: internal levels
  // pins are read whatever their port direction, so driving them raises requests [RQ8]
  wire [EPIU_N_ASYNC-1:0] buf_off;
  wire [EPIU_N_ASYNC-1:0] pin_lo_int;
  wire [EPIU_SENSE_W*EPIU_N_DED-1:0] sense_all = {sense_hi_r, sense_lo_r};

  // disabled inputs 0-3 lose their buffer in sleep; the forced level may set flags [RQ12]
  assign buf_off = {EPIU_N_ASYNC{sleep_active}} & ~ext_mask_r[EPIU_N_ASYNC-1:0];
  assign pin_lo_int = buf_gate(dedicated_irq_pin[EPIU_N_ASYNC-1:0], buf_off);

  wire [EPIU_N_DED-1:0] cur_lvl;
  wire [EPIU_N_DED-1:0] prev_lvl;
  wire [EPIU_N_DED-1:0] sample_ok;
  wire [EPIU_N_DED-1:0] is_level;
  wire [EPIU_N_DED-1:0] low_level;
  wire [EPIU_N_DED-1:0] edge_hit;

  // inputs 0-3 compare the live level with the last clock's level, no sample stage [RQ3]
  assign cur_lvl[EPIU_N_ASYNC-1:0] = pin_lo_int; // [RQ1]
  assign prev_lvl[EPIU_N_ASYNC-1:0] = async_prev_r;
  assign sample_ok[EPIU_N_ASYNC-1:0] = {EPIU_N_ASYNC{1'b1}}; // [RQ18]

  // inputs 4-7 compare the new sample with the one before, only on io clock ticks [RQ4]
  assign cur_lvl[EPIU_N_DED-1:EPIU_N_ASYNC] = dedicated_irq_pin[EPIU_N_DED-1:EPIU_N_ASYNC];
  assign prev_lvl[EPIU_N_DED-1:EPIU_N_ASYNC] = sample_r; // [RQ2]
  assign sample_ok[EPIU_N_DED-1:EPIU_N_ASYNC] = {(EPIU_N_DED-EPIU_N_ASYNC){io_clk_en}}; // [RQ18]

  // =====================================================================
  // dedicated inputs: trigger decode
  genvar gi;
  generate
    for (gi = 0; gi < EPIU_N_DED; gi++) begin : g_ded
      epiu_sense_decode u_dec (
        .mode(sense_field(sense_all, gi)),
        .cur(cur_lvl[gi]),
        .prev(prev_lvl[gi]),
        .sample_ok(sample_ok[gi]),
        .is_level(is_level[gi]),
        .low_level(low_level[gi]),
        .edge_hit(edge_hit[gi])
      );
    end
  endgenerate

  // =====================================================================
  // dedicated inputs: level history
  // history resets low; sense resets to level, so the first compare sets nothing
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      async_prev_r <= '0;
    end else begin
      async_prev_r <= pin_lo_int;
    end
  end

  // samples advance only while the io clock runs
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sample_r <= '0;
    end else if (io_clk_en) begin
      sample_r <= dedicated_irq_pin[EPIU_N_DED-1:EPIU_N_ASYNC]; // [RQ4]
    end
  end

  // =====================================================================
  // dedicated flags
  wire [EPIU_N_DED-1:0] ext_flag_clr = (wr_ext_flags ? reg_wdata : EPIU_RST_BYTE) |
                                       ext_vector_ack;

  // sense changes are not blocked: software follows the disable/clear/enable order [RQ9]
  always_comb begin
    ext_flag_nxt = flag_next(ext_flag_r, edge_hit, ext_flag_clr); // [RQ10]
    ext_flag_nxt = ext_flag_nxt & ~is_level; // [RQ11]
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ext_flag_r <= EPIU_RST_BYTE;
    end else begin
      ext_flag_r <= ext_flag_nxt;
    end
  end

  // =====================================================================
  // dedicated requests
  // level mode requests straight from the pin for as long as it stays low [RQ6]
  // a short low level may vanish before it is taken; holding it is the source's job [RQ5]
  wire [EPIU_N_DED-1:0] ext_active = (is_level & low_level) | (~is_level & ext_flag_r);

  assign ext_irq_req = req_gate(ext_active, ext_mask_r, global_irq_enable); // [RQ7] [RQ19]

  // =====================================================================
  // pin-change groups
  wire chg_lo;
  wire chg_hi;

  epiu_change_group #(
    .W(EPIU_N_PCH_LO)
  ) u_grp_lo (
    .mclk(mclk),
    .rst_b(rst_b),
    .pins(change_watch_pin[EPIU_N_PCH_LO-1:0]),
    .mask(pcm_lo_r), // [RQ15]
    .change(chg_lo) // [RQ17]
  );

  epiu_change_group #(
    .W(EPIU_N_PCH_HI)
  ) u_grp_hi (
    .mclk(mclk),
    .rst_b(rst_b),
    .pins(change_watch_pin[EPIU_N_PCH-1:EPIU_N_PCH_LO]),
    .mask(pcm_hi_r[EPIU_N_PCH_HI-1:0]), // [RQ16]
    .change(chg_hi) // [RQ17]
  );

  wire [EPIU_N_GRP-1:0] grp_change = {chg_hi, chg_lo};

  // =====================================================================
  // group flags
  wire epiu_byte_t grp_set = {{(EPIU_DW-EPIU_N_GRP){1'b0}}, grp_change};
  wire epiu_byte_t grp_ack = {{(EPIU_DW-EPIU_N_GRP){1'b0}}, group_vector_ack};
  wire epiu_byte_t grp_clr = ((wr_pch_flags ? reg_wdata : EPIU_RST_BYTE) | grp_ack) &
                             EPIU_BITS_GRP;

  // a change in the same cycle as a clear leaves the flag set
  always_comb begin
    grp_flag_nxt = flag_next(grp_flag_r, grp_set, grp_clr) & EPIU_BITS_GRP; // [RQ14]
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      grp_flag_r <= EPIU_RST_BYTE;
    end else begin
      grp_flag_r <= grp_flag_nxt;
    end
  end

  // =====================================================================
  // group requests
  wire epiu_byte_t grp_req_all = req_gate(grp_flag_r, grp_en_r, global_irq_enable);
  assign group_irq_req = grp_req_all[EPIU_N_GRP-1:0]; // [RQ13] [RQ19]

  // =====================================================================
  // configuration registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sense_lo_r <= EPIU_RST_BYTE;
    end else if (wr_sense_lo) begin
      sense_lo_r <= reg_wdata; // [RQ1]
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sense_hi_r <= EPIU_RST_BYTE;
    end else if (wr_sense_hi) begin
      sense_hi_r <= reg_wdata; // [RQ2]
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ext_mask_r <= EPIU_RST_BYTE;
    end else if (wr_ext_mask) begin
      ext_mask_r <= reg_wdata; // [RQ7]
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      grp_en_r <= EPIU_RST_BYTE;
    end else if (wr_grp_en) begin
      grp_en_r <= masked_write(reg_wdata, EPIU_BITS_GRP); // [RQ13]
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pcm_lo_r <= EPIU_RST_BYTE;
    end else if (wr_pcm_lo) begin
      pcm_lo_r <= masked_write(reg_wdata, EPIU_BITS_ALL); // [RQ15]
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pcm_hi_r <= EPIU_RST_BYTE;
    end else if (wr_pcm_hi) begin
      pcm_hi_r <= masked_write(reg_wdata, EPIU_BITS_PCM_HI); // [RQ16]
    end
  end

  // =====================================================================
  // read port: data stand only in the cycle after the read strobe
  always_comb begin
    if (hit_pch_flags) begin
      rdata_nxt = grp_flag_r;
    end else if (hit_ext_flags) begin
      rdata_nxt = ext_flag_r & ~is_level; // [RQ11]
    end else if (hit_ext_mask) begin
      rdata_nxt = ext_mask_r;
    end else if (hit_grp_en) begin
      rdata_nxt = grp_en_r;
    end else if (hit_sense_lo) begin
      rdata_nxt = sense_lo_r;
    end else if (hit_sense_hi) begin
      rdata_nxt = sense_hi_r;
    end else if (hit_pcm_lo) begin
      rdata_nxt = pcm_lo_r;
    end else if (hit_pcm_hi) begin
      rdata_nxt = pcm_hi_r;
    end else begin
      // unmapped offsets read zero
      rdata_nxt = EPIU_READ_NONE;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= EPIU_READ_NONE;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= EPIU_READ_NONE;
    end
  end

  assign reg_rdata = rdata_r;

endmodule
`default_nettype wire
